// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int CNT_W = 16;
  typedef struct packed {
    logic [7:0] ev;
    logic [5:0] pulses;
    logic [3:0] flags;
  } tre_row_t;

  logic                              mclk;
  logic                              rst;
  logic                              ce;
  logic [tre_pkg::ADDR_W-1:0]        reg_addr;
  logic [tre_pkg::REG_W-1:0]         reg_wdata;
  logic                              reg_wr;
  logic                              reg_rd;
  logic [tre_pkg::REG_W-1:0]         reg_rdata;
  logic                              count_down;
  logic [CNT_W-1:0]                  count_value;
  logic [CNT_W-1:0]                  auto_reload_value;
  logic [tre_pkg::CHANS-1:0]         chan_input_mode;
  logic [tre_pkg::CHANS-1:0]         hw_capture;
  logic [tre_pkg::CHANS-1:0]         hw_match;
  logic                              hw_trigger;
  logic                              update_event;
  logic                              counter_load;
  logic [CNT_W-1:0]                  counter_load_value;
  logic                              prescaler_clear;
  logic                              control_update_event;
  logic                              trigger_event;
  logic                              break_event;
  logic [tre_pkg::CHANS-1:0]         chan_match_capture_flag;
  logic [tre_pkg::CHANS-1:0]         chan_repeat_capture_flag;
  logic [tre_pkg::CHANS*CNT_W-1:0]   chan_capture_compare_value;
  logic [tre_pkg::CHANS-1:0]         chan_irq_request;
  logic                              irq;
  logic [5:0]                        pulses;
  int                                fails;
  int                                compares;
  int                                cycles;
  // Ordinary cases: event bits with the pulses and channel flags they should give
  tre_row_t rows [9] = '{'{8'h01, 6'b111000, 4'h0}, '{8'h02, 6'b000000, 4'h1},
                         '{8'h04, 6'b000000, 4'h2}, '{8'h08, 6'b000000, 4'h4},
                         '{8'h10, 6'b000000, 4'h8}, '{8'h20, 6'b000100, 4'h0},
                         '{8'h40, 6'b000010, 4'h0}, '{8'h80, 6'b000001, 4'h0},
                         '{8'h00, 6'b000000, 4'h0}};

  // All event pulses gathered so one compare covers them
  assign pulses = {update_event, counter_load, prescaler_clear,
                   control_update_event, trigger_event, break_event};

  tre_timer_events #(.CNT_W(CNT_W)) dut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_down(count_down), .count_value(count_value), .auto_reload_value(auto_reload_value),
    .chan_input_mode(chan_input_mode), .hw_capture(hw_capture), .hw_match(hw_match),
    .hw_trigger(hw_trigger), .update_event(update_event), .counter_load(counter_load),
    .counter_load_value(counter_load_value), .prescaler_clear(prescaler_clear),
    .control_update_event(control_update_event), .trigger_event(trigger_event),
    .break_event(break_event), .chan_match_capture_flag(chan_match_capture_flag),
    .chan_repeat_capture_flag(chan_repeat_capture_flag),
    .chan_capture_compare_value(chan_capture_compare_value),
    .chan_irq_request(chan_irq_request), .irq(irq));

  // Clock at 200 MHz
  always #2.5 mclk = ~mclk;

  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s read %h expected %h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp,
                         input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s is %h expected %h", $time, what, got, exp);
    end
  endtask : chk_out

  // One-cycle write strobe; returns at the edge that takes it
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string what);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk_reg(reg_rdata, exp, what);
    @(posedge mclk);
    #1 chk_reg(reg_rdata, 32'h0, "read data idle");
  endtask : rd

  // One edge after a write, flags and captures have landed
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask : settle

  initial begin
    mclk = 1'b0; rst = 1'b1; ce = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0;
    reg_wr = 1'b0; reg_rd = 1'b0; count_down = 1'b0; count_value = 16'h0000;
    auto_reload_value = 16'h0000; chan_input_mode = 4'h0; hw_capture = 4'h0;
    hw_match = 4'h0; hw_trigger = 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk_out({12'h0, chan_repeat_capture_flag}, 16'h0, "repeat flags in reset");
    @(posedge mclk);
    rst <= 1'b0;
    rd(tre_pkg::OFF_REPEAT, 32'h0, "repeat reset value");
    // Ordinary cases from the table
    foreach (rows[i]) begin
      wr(tre_pkg::OFF_EVT_CLEAR, 32'hff);
      wr(tre_pkg::OFF_SW_EVENT, {24'h0, rows[i].ev});
      #1 chk_out({10'h0, pulses}, 16'(rows[i].pulses), "event pulses");
      settle();
      chk_out({10'h0, pulses}, 16'h0, "pulses self clear");
      chk_out({12'h0, chan_match_capture_flag}, 16'(rows[i].flags), "channel flags");
      rd(tre_pkg::OFF_EVT_STATUS, {25'h0, rows[i].ev[6], 1'b0, rows[i].flags, 1'b0},
         "status");
      rd(tre_pkg::OFF_SW_EVENT, 32'h0, "event register");
    end
    // Enable low: a write is not taken and no state moves
    @(posedge mclk);
    ce <= 1'b0;
    wr(tre_pkg::OFF_SW_EVENT, 32'hff);
    settle();
    chk_out({10'h0, pulses}, 16'h0, "pulses with enable low");
    chk_out({12'h0, chan_match_capture_flag}, 16'h0, "flags with enable low");
    @(posedge mclk);
    ce <= 1'b1;
    // Update reload value by direction
    @(posedge mclk);
    count_down        <= 1'b1;
    auto_reload_value <= 16'h1234;
    wr(tre_pkg::OFF_SW_EVENT, 32'h1);
    #1 chk_out(counter_load_value, 16'h1234, "down reload");
    @(posedge mclk);
    count_down <= 1'b0;
    wr(tre_pkg::OFF_SW_EVENT, 32'h1);
    #1 chk_out(counter_load_value, 16'h0000, "up reload");
    // Software capture twice in input mode gives the repeat flag
    @(posedge mclk);
    chan_input_mode <= 4'hf;
    count_value     <= 16'h00a5;
    wr(tre_pkg::OFF_EVT_CLEAR, 32'hff);
    wr(tre_pkg::OFF_SW_EVENT, 32'h1e);
    settle();
    chk_out({12'h0, chan_repeat_capture_flag}, 16'h0, "no repeat on first capture");
    for (int g = 0; g < 4; g++)
      chk_out(chan_capture_compare_value[g*CNT_W +: CNT_W], 16'h00a5, "capture");
    @(posedge mclk);
    count_value <= 16'h005a;
    wr(tre_pkg::OFF_SW_EVENT, 32'h1e);
    settle();
    chk_out({12'h0, chan_repeat_capture_flag}, 16'hf, "repeat flags");
    rd(tre_pkg::OFF_REPEAT, 32'h1e, "repeat register");
    for (int g = 0; g < 4; g++)
      rd(tre_pkg::OFF_CAPT_BASE + 8'(g) * tre_pkg::OFF_CAPT_STEP, 32'h5a, "capture reg");
    wr(tre_pkg::OFF_REPEAT, 32'hffff_fffd);
    rd(tre_pkg::OFF_REPEAT, 32'h1c, "repeat clear one");
    // Hardware capture, ignored match in input mode, hardware trigger
    wr(tre_pkg::OFF_EVT_CLEAR, 32'hff);
    @(posedge mclk);
    hw_capture <= 4'h2;
    hw_match   <= 4'h4;
    hw_trigger <= 1'b1;
    @(posedge mclk);
    hw_capture <= 4'h0;
    hw_match   <= 4'h0;
    hw_trigger <= 1'b0;
    settle();
    rd(tre_pkg::OFF_EVT_STATUS, 32'h44, "hardware events");
    // Output mode never sets a repeat flag
    @(posedge mclk);
    chan_input_mode <= 4'h0;
    wr(tre_pkg::OFF_REPEAT, 32'h0);
    wr(tre_pkg::OFF_SW_EVENT, 32'h1e);
    wr(tre_pkg::OFF_SW_EVENT, 32'h1e);
    settle();
    rd(tre_pkg::OFF_REPEAT, 32'h0, "repeat in output mode");
    // Interrupt gating, raise, mask and clear
    wr(tre_pkg::OFF_EVT_CLEAR, 32'hff);
    wr(tre_pkg::OFF_IRQ_ENABLE, 32'hffff_ffff);
    rd(tre_pkg::OFF_IRQ_ENABLE, 32'h5e, "enable reserved bits");
    wr(tre_pkg::OFF_IRQ_ENABLE, 32'h02);
    wr(tre_pkg::OFF_SW_EVENT, 32'h04);
    settle();
    chk_out({12'h0, chan_irq_request}, 16'h0, "masked request");
    chk_out(16'(irq), 16'h0, "masked irq");
    wr(tre_pkg::OFF_SW_EVENT, 32'h02);
    settle();
    chk_out({12'h0, chan_irq_request}, 16'h1, "enabled request");
    chk_out(16'(irq), 16'h1, "irq raised");
    wr(tre_pkg::OFF_IRQ_ENABLE, 32'h0);
    settle();
    chk_out(16'(irq), 16'h0, "irq masked");
    wr(tre_pkg::OFF_IRQ_ENABLE, 32'h02);
    wr(tre_pkg::OFF_EVT_CLEAR, 32'h02);
    settle();
    chk_out(16'(irq), 16'h0, "irq cleared");
    // Reset in mid-run drops flags and enables again
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1 chk_out({12'h0, chan_match_capture_flag}, 16'h0, "flags after reset");
    rd(tre_pkg::OFF_IRQ_ENABLE, 32'h0, "enable after reset");
    rd(8'h30, 32'h0, "unmapped read");
    results();
  end
endmodule : tb

// ### common/tre_chan_if.sv
`timescale 1ns/1ps
// Per-channel signals between the event controller and one channel slice
interface tre_chan_if #(
  parameter int CNT_W = 16
);
  logic             ce;
  logic             sw_event;
  logic             hw_capture;
  logic             hw_match;
  logic             input_mode;
  logic             flag_clear;
  logic             repeat_clear;
  logic [CNT_W-1:0] count_value;
  logic             flag;
  logic             repeat_flag;
  logic [CNT_W-1:0] capture_value;

  modport ctrl (
    output ce, sw_event, hw_capture, hw_match, input_mode, flag_clear, repeat_clear,
    output count_value,
    input  flag, repeat_flag, capture_value
  );
  modport chan (
    input  ce, sw_event, hw_capture, hw_match, input_mode, flag_clear, repeat_clear,
    input  count_value,
    output flag, repeat_flag, capture_value
  );
endinterface : tre_chan_if

// ### common/tre_pkg.sv
// Contract
// R1: Channel 1 repeat-capture flag is set by hardware only while the channel is an input capture, reads 1 after a repeat capture, and is cleared by software.
// R2: Channels 2 to 4 each have an identical repeat-capture flag at bits 2, 3 and 4 of the repeat-capture register.
// R3: Writing 1 to bit 0 of the event register reinitialises the counter and raises an update event, and the bit clears itself.
// R4: An update event clears the prescaler internal counter but leaves the division factor alone.
// R5: An update event while counting down loads the counter with the auto-reload value.
// R6: An update event while counting up or center-aligned loads the counter with zero.
// R7: Writing 1 to bit 1 with channel 1 in output mode sets the channel 1 flag, which requests an interrupt when enabled, and the bit clears itself.
// R8: With channel 1 in input mode a software event copies the counter into the channel 1 capture register and sets the channel flag.
// R9: A software-forced capture while the channel 1 flag is already 1 also sets the channel 1 repeat-capture flag.
// R10: Bits 2, 3 and 4 of the event register do the same for channels 2, 3 and 4.
// R11: Writing 1 to bit 5 raises a control update event for complementary channels and the bit clears itself.
// R12: Writing 1 to bit 6 raises a trigger event and the bit clears itself.
// R13: Writing 1 to bit 7 raises a break event and the bit clears itself.
// R14: Any trigger event, software ones included, sets the trigger flag, which only software clears.
// R15: Each channel interrupt request is gated by its own enable bit, 0 off and 1 on.
// R16: Writing 0 to an event bit does nothing, and reserved bits read zero and ignore writes.
// R17: The event register always reads back zero.
package tre_pkg;
  localparam int CHANS = 4;
  localparam int REG_W = 32;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_REPEAT     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SW_EVENT   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR  = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_CAPT_BASE  = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_CAPT_STEP  = 8'h04;
  // Field positions
  localparam int BIT_UPDATE   = 0;
  localparam int BIT_CHAN0    = 1;
  localparam int BIT_CTRL_UPD = 5;
  localparam int BIT_TRIGGER  = 6;
  localparam int BIT_BREAK    = 7;
  localparam int EVT_W        = 8;
  // Implemented bits of the status and enable layout
  localparam logic [EVT_W-1:0] STATUS_MASK = 8'h5e;
  localparam logic [EVT_W-1:0] REPEAT_MASK = 8'h1e;
  localparam logic [EVT_W-1:0] EVT_RESET   = 8'h00;
  localparam logic [REG_W-1:0] READ_ZERO   = 32'h0000_0000;
endpackage : tre_pkg

// ### design/tre_chan_slice.sv
`timescale 1ns/1ps
// One capture/compare channel: match/capture flag, repeat flag, captured value
module tre_chan_slice #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  tre_chan_if.chan ch
);
  wire capture_hit;
  wire set_flag;
  wire set_repeat;
  wire next_flag;
  wire next_repeat;

  // Captures only happen in input mode; a software event always raises the flag
  assign capture_hit = ch.input_mode & (ch.sw_event | ch.hw_capture); // R8
  assign set_flag    = ch.sw_event | (ch.input_mode ? ch.hw_capture : ch.hw_match); // R7
  assign set_repeat  = capture_hit & ch.flag; // R9
  // Set wins over a clear arriving in the same cycle
  assign next_flag   = set_flag | (ch.flag & ~ch.flag_clear);
  assign next_repeat = set_repeat | (ch.repeat_flag & ~ch.repeat_clear); // R1

  // Flag state, frozen while the clock enable is low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ch.flag          <= 1'b0;
      ch.repeat_flag   <= 1'b0;
      ch.capture_value <= '0;
    end else if (ch.ce) begin
      ch.flag        <= next_flag;
      ch.repeat_flag <= next_repeat;
      if (capture_hit) begin
        ch.capture_value <= ch.count_value; // R8
      end
    end
  end

  a_repeat_input_only: assert property (@(posedge mclk) disable iff (rst) // R1
    $rose(ch.repeat_flag) |-> $past(ch.input_mode))
    else $error("repeat flag set outside input mode");

  a_capture_copies_count: assert property (@(posedge mclk) disable iff (rst) // R8
    ch.ce && ch.sw_event && ch.input_mode |=> ch.capture_value == $past(ch.count_value) && ch.flag)
    else $error("software capture did not copy the counter");

  a_repeat_on_second: assert property (@(posedge mclk) disable iff (rst) // R9
    ch.ce && ch.sw_event && ch.input_mode && ch.flag |=> ch.repeat_flag)
    else $error("second capture did not raise the repeat flag");

  a_output_sw_flag: assert property (@(posedge mclk) disable iff (rst) // R7
    ch.ce && ch.sw_event && !ch.input_mode |=> ch.flag && $stable(ch.capture_value))
    else $error("software compare event mishandled");
endmodule : tre_chan_slice

// ### design/tre_timer_events.sv
`timescale 1ns/1ps
// Repeat-capture status and software event generation for a four-channel timer
module tre_timer_events #(
  parameter int CNT_W = 16
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [tre_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [tre_pkg::REG_W-1:0]     reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [tre_pkg::REG_W-1:0]     reg_rdata,
  input  wire logic                          count_down,
  input  wire logic [CNT_W-1:0]              count_value,
  input  wire logic [CNT_W-1:0]              auto_reload_value,
  input  wire logic [tre_pkg::CHANS-1:0]     chan_input_mode,
  input  wire logic [tre_pkg::CHANS-1:0]     hw_capture,
  input  wire logic [tre_pkg::CHANS-1:0]     hw_match,
  input  wire logic                          hw_trigger,
  output logic                               update_event,
  output logic                               counter_load,
  output logic      [CNT_W-1:0]              counter_load_value,
  output logic                               prescaler_clear,
  output logic                               control_update_event,
  output logic                               trigger_event,
  output logic                               break_event,
  output logic      [tre_pkg::CHANS-1:0]     chan_match_capture_flag,
  output logic      [tre_pkg::CHANS-1:0]     chan_repeat_capture_flag,
  output logic      [tre_pkg::CHANS*CNT_W-1:0] chan_capture_compare_value,
  output logic      [tre_pkg::CHANS-1:0]     chan_irq_request,
  output logic                               irq
);
  localparam int CH = tre_pkg::CHANS;
  localparam int EW = tre_pkg::EVT_W;
  localparam int AW = tre_pkg::ADDR_W;
  localparam int RW = tre_pkg::REG_W;
  // Checks share one clock; all but a_freeze_when_off skip reset and frozen cycles
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || !ce);

  // Address match, shared by every strobe and the read mux
  function automatic logic hit(input logic [tre_pkg::ADDR_W-1:0] a,
                               input logic [tre_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic [EW-1:0]       sw_pulse;
  logic [EW-1:0]       irq_enable;
  logic                trigger_irq_flag;
  logic [CNT_W-1:0]    next_load_value;
  wire                 wr_event;
  wire                 wr_repeat;
  wire                 wr_clear;
  wire                 wr_enable;
  wire  [EW-1:0]       wbits;
  wire  [EW-1:0]       next_sw_pulse;
  wire  [EW-1:0]       evt_status;
  wire  [EW-1:0]       repeat_status;
  wire                 trigger_set;
  wire                 trigger_clr;
  wire                 next_trigger_flag;
  wire  [CH-1:0]       chan_flag;
  wire  [CH-1:0]       chan_repeat;
  wire  [CNT_W-1:0]    capt_val [CH];
  wire  [CNT_W-1:0]    capt_rd [CH+1];
  logic [tre_pkg::REG_W-1:0] next_rdata;

  // Write strobes
  assign wbits     = reg_wdata[EW-1:0];
  assign wr_event  = reg_wr & hit(reg_addr, tre_pkg::OFF_SW_EVENT);
  assign wr_repeat = reg_wr & hit(reg_addr, tre_pkg::OFF_REPEAT);
  assign wr_clear  = reg_wr & hit(reg_addr, tre_pkg::OFF_EVT_CLEAR);
  assign wr_enable = reg_wr & hit(reg_addr, tre_pkg::OFF_IRQ_ENABLE);

  // Event bits live one cycle only; zeros written leave nothing behind
  assign next_sw_pulse = wr_event ? wbits : tre_pkg::EVT_RESET; // R16
  // Reload value is picked at write time so the load data comes from a flop
  always_comb begin
    next_load_value = counter_load_value;
    if (wr_event && wbits[tre_pkg::BIT_UPDATE]) begin
      next_load_value = count_down ? auto_reload_value : '0; // R5 R6
    end
  end

  // Self-clearing event register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sw_pulse           <= tre_pkg::EVT_RESET;
      counter_load_value <= '0;
    end else if (ce) begin
      sw_pulse           <= next_sw_pulse; // R3 R17
      counter_load_value <= next_load_value;
    end
  end

  // Event pulses, each one cycle wide
  assign update_event         = sw_pulse[tre_pkg::BIT_UPDATE]; // R3
  assign counter_load         = sw_pulse[tre_pkg::BIT_UPDATE]; // R3
  assign prescaler_clear      = sw_pulse[tre_pkg::BIT_UPDATE]; // R4
  assign control_update_event = sw_pulse[tre_pkg::BIT_CTRL_UPD]; // R11
  assign trigger_event        = sw_pulse[tre_pkg::BIT_TRIGGER]; // R12
  assign break_event          = sw_pulse[tre_pkg::BIT_BREAK]; // R13

  // Trigger flag: software or hardware trigger sets, clear register clears, set wins
  assign trigger_set       = trigger_event | hw_trigger; // R14
  assign trigger_clr       = wr_clear & wbits[tre_pkg::BIT_TRIGGER];
  assign next_trigger_flag = trigger_set | (trigger_irq_flag & ~trigger_clr); // R14

  // Trigger flag and interrupt enables
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trigger_irq_flag <= 1'b0;
      irq_enable       <= tre_pkg::EVT_RESET;
    end else if (ce) begin
      trigger_irq_flag <= next_trigger_flag;
      if (wr_enable) begin
        irq_enable <= wbits & tre_pkg::STATUS_MASK; // R16
      end
    end
  end

  // Channel slices, one per capture/compare channel
  tre_chan_if #(.CNT_W(CNT_W)) ch_if [CH] ();
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_chan
      assign ch_if[g].ce           = ce;
      assign ch_if[g].sw_event     = sw_pulse[tre_pkg::BIT_CHAN0 + g]; // R10
      assign ch_if[g].hw_capture   = hw_capture[g];
      assign ch_if[g].hw_match     = hw_match[g];
      assign ch_if[g].input_mode   = chan_input_mode[g];
      assign ch_if[g].count_value  = count_value;
      assign ch_if[g].flag_clear   = wr_clear & wbits[tre_pkg::BIT_CHAN0 + g];
      // Repeat flags clear on a written zero; a written one leaves them alone
      assign ch_if[g].repeat_clear = wr_repeat & ~wbits[tre_pkg::BIT_CHAN0 + g]; // R2
      assign chan_flag[g]          = ch_if[g].flag;
      assign chan_repeat[g]        = ch_if[g].repeat_flag; // R2
      assign capt_val[g]           = ch_if[g].capture_value;
      assign chan_capture_compare_value[g*CNT_W +: CNT_W] = ch_if[g].capture_value;
      assign chan_irq_request[g]   = ch_if[g].flag & irq_enable[tre_pkg::BIT_CHAN0 + g]; // R15
      // Capture value read select, chained through the channels
      assign capt_rd[g+1] = hit(reg_addr, AW'(tre_pkg::OFF_CAPT_BASE
                                + tre_pkg::OFF_CAPT_STEP * g)) ? capt_val[g] : capt_rd[g];
      tre_chan_slice #(.CNT_W(CNT_W)) u_slice (
        .mclk (mclk),
        .rst  (rst),
        .ch   (ch_if[g])
      );
      // Each channel honours its own enable and its own event bit
      a_chan_gate_each: assert property ( // R15
        !irq_enable[tre_pkg::BIT_CHAN0 + g] |-> !chan_irq_request[g])
        else $error("channel request not gated");
      a_chan_event_each: assert property ( // R10
        sw_pulse[tre_pkg::BIT_CHAN0 + g] |=> chan_flag[g])
        else $error("channel event lost");
    end
  endgenerate
  assign capt_rd[0] = '0;

  // Status layouts; unimplemented bits stay zero
  assign evt_status    = {1'b0, trigger_irq_flag, 1'b0, chan_flag, 1'b0} & tre_pkg::STATUS_MASK;
  assign repeat_status = {3'b000, chan_repeat, 1'b0} & tre_pkg::REPEAT_MASK; // R16
  assign chan_match_capture_flag  = chan_flag;
  assign chan_repeat_capture_flag = chan_repeat;
  // Level interrupt; stays high until every enabled flag is cleared
  assign irq = |(evt_status & irq_enable); // R15

  // Read mux; the event and clear registers are write-only and read zero
  always_comb begin
    next_rdata = tre_pkg::READ_ZERO;
    if (hit(reg_addr, tre_pkg::OFF_EVT_STATUS)) begin
      next_rdata[EW-1:0] = evt_status;
    end else if (hit(reg_addr, tre_pkg::OFF_REPEAT)) begin
      next_rdata[EW-1:0] = repeat_status;
    end else if (hit(reg_addr, tre_pkg::OFF_IRQ_ENABLE)) begin
      next_rdata[EW-1:0] = irq_enable;
    end else if (hit(reg_addr, tre_pkg::OFF_SW_EVENT)) begin
      next_rdata = tre_pkg::READ_ZERO; // R17
    end else begin
      next_rdata[CNT_W-1:0] = capt_rd[CH];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= tre_pkg::READ_ZERO;
    end else if (ce) begin
      reg_rdata <= reg_rd ? next_rdata : tre_pkg::READ_ZERO;
    end
  end

  // Checks
  sequence s_event_write(int b);
    ce && wr_event && wbits[b];
  endsequence

  sequence s_clear_write(int b);
    ce && wr_clear && wbits[b];
  endsequence

  sequence s_read_of(logic [AW-1:0] a);
    ce && reg_rd && hit(reg_addr, a);
  endsequence

  a_update_one_shot: assert property (@(posedge mclk) disable iff (rst || !ce) // R3
    s_event_write(tre_pkg::BIT_UPDATE) |=> update_event && counter_load ##1 !update_event)
    else $error("update event not a single pulse");

  a_prescaler_with_update: assert property (@(posedge mclk) disable iff (rst || !ce) // R4
    s_event_write(tre_pkg::BIT_UPDATE) |=> prescaler_clear ##1 !prescaler_clear)
    else $error("prescaler not cleared on update");

  a_reload_down: assert property (@(posedge mclk) disable iff (rst || !ce) // R5
    s_event_write(tre_pkg::BIT_UPDATE) ##0 count_down
      |=> counter_load_value == $past(auto_reload_value))
    else $error("down count did not load the reload value");

  a_reload_up: assert property (@(posedge mclk) disable iff (rst || !ce) // R6
    s_event_write(tre_pkg::BIT_UPDATE) ##0 !count_down |=> counter_load_value == '0)
    else $error("up count did not load zero");

  a_ctrl_update_pulse: assert property (@(posedge mclk) disable iff (rst || !ce) // R11
    s_event_write(tre_pkg::BIT_CTRL_UPD) |=> control_update_event ##1 !control_update_event)
    else $error("control update pulse wrong");

  a_trigger_sets_flag: assert property (@(posedge mclk) disable iff (rst || !ce) // R12 R14
    s_event_write(tre_pkg::BIT_TRIGGER) |=> trigger_event ##1 trigger_irq_flag)
    else $error("software trigger did not set the flag");

  a_break_pulse: assert property (@(posedge mclk) disable iff (rst || !ce) // R13
    s_event_write(tre_pkg::BIT_BREAK) |=> break_event ##1 !break_event)
    else $error("break pulse wrong");

  a_zero_write_idle: assert property (@(posedge mclk) disable iff (rst || !ce) // R16
    ce && wr_event && wbits == '0 |=> sw_pulse == '0)
    else $error("zero write raised an event");

  a_event_reads_zero: assert property (@(posedge mclk) disable iff (rst || !ce) // R17
    reg_rd && hit(reg_addr, tre_pkg::OFF_SW_EVENT) |=> reg_rdata == '0)
    else $error("event register read nonzero");

  a_chan_irq_gate: assert property (@(posedge mclk) disable iff (rst || !ce) // R7 R15
    s_event_write(tre_pkg::BIT_CHAN0) ##0 irq_enable[tre_pkg::BIT_CHAN0] |=> ##1 irq)
    else $error("enabled channel event gave no interrupt");

  // Trigger flag is sticky; only a clear with no new trigger drops it
  a_trigger_set_wins: assert property ( // R14
    trigger_set |=> trigger_irq_flag)
    else $error("trigger flag not set");

  a_trigger_clears: assert property ( // R14
    s_clear_write(tre_pkg::BIT_TRIGGER) ##0 !trigger_set |=> !trigger_irq_flag)
    else $error("trigger flag not cleared");

  a_trigger_sticky: assert property ( // R14
    trigger_irq_flag && !trigger_clr |=> trigger_irq_flag)
    else $error("trigger flag dropped");

  a_irq_needs_enable: assert property ( // R15
    irq_enable == '0 |-> !irq)
    else $error("irq with no enable");

  a_irq_from_request: assert property ( // R15
    chan_irq_request != '0 |-> irq)
    else $error("request gave no irq");

  a_enable_reserved: assert property ( // R16
    (irq_enable & ~tre_pkg::STATUS_MASK) == '0)
    else $error("reserved enable bit set");

  a_status_reserved: assert property ( // R16
    s_read_of(tre_pkg::OFF_EVT_STATUS) |=> (reg_rdata & ~RW'(tre_pkg::STATUS_MASK)) == '0)
    else $error("status reserved bit set");

  a_repeat_reserved: assert property ( // R16
    s_read_of(tre_pkg::OFF_REPEAT) |=> (reg_rdata & ~RW'(tre_pkg::REPEAT_MASK)) == '0)
    else $error("repeat reserved bit set");

  a_repeat_keep_one: assert property ( // R2
    wr_repeat && wbits[tre_pkg::BIT_CHAN0 + 1] && chan_repeat[1] |=> chan_repeat[1])
    else $error("written one cleared repeat");

  a_repeat_clear_zero: assert property ( // R1
    wr_repeat && !wbits[tre_pkg::BIT_CHAN0] && !sw_pulse[tre_pkg::BIT_CHAN0]
      && !hw_capture[0] |=> !chan_repeat[0])
    else $error("written zero kept repeat");

  a_pulse_needs_write: assert property ( // R16
    !wr_event |=> sw_pulse == '0)
    else $error("pulse without a write");

  a_load_holds: assert property ( // R5 R6
    !(wr_event && wbits[tre_pkg::BIT_UPDATE]) |=> $stable(counter_load_value))
    else $error("load value moved");

  a_freeze_when_off: assert property (disable iff (rst) // R3 R14
    !ce |=> $stable(sw_pulse) && $stable(trigger_irq_flag) && $stable(reg_rdata))
    else $error("state moved with enable low");

  a_read_one_cycle: assert property ( // R17
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outlived its cycle");

  a_capture_read: assert property ( // R8
    s_read_of(tre_pkg::OFF_CAPT_BASE) |=> reg_rdata[CNT_W-1:0] == $past(capt_val[0]))
    else $error("capture read wrong");
endmodule : tre_timer_events
